// >>> src/fpp_pkg.sv
// Package for the four-pin port: register map, field layouts, reset values and modes.
package fpp_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] FPP_OFF_DATA = 8'h00;
    localparam logic [7:0] FPP_OFF_DIR = 8'h04;
    localparam logic [7:0] FPP_OFF_MUX = 8'h08;
    localparam logic [7:0] FPP_OFF_PWR = 8'h0c;

    // ---------------------------------------------------------------
    // Reset and read-back values
    // ---------------------------------------------------------------
    localparam logic [7:0] FPP_DATA_RST = 8'hf8;
    localparam logic [7:0] FPP_DIR_RST = 8'hf8;
    localparam logic [7:0] FPP_DIR_READ = 8'hff;
    localparam logic [3:0] FPP_DATA_UNUSED = 4'hf;
    localparam logic [6:0] FPP_MUX_RST = 7'h00;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int FPP_GPIO_LSB = 0;
    localparam int FPP_GPIO_W = 3;
    localparam int FPP_IN_PIN = 3;
    localparam int FPP_MUX_W = 7;
    localparam int FPP_PWR_W = 2;

    // ---------------------------------------------------------------
    // Bus responses
    // ---------------------------------------------------------------
    localparam logic [1:0] FPP_RESP_OKAY = 2'h0;
    localparam logic [1:0] FPP_RESP_SLVERR = 2'h2;

    // Pin multiplexer control, bit 6 first, down to bit 0
    typedef struct packed {
        logic tx_pin_ctl;
        logic comm_mode;
        logic clk_en_lo;
        logic clk_en_hi;
        logic rx_en;
        logic tx_en;
        logic irq_sel;
    } fpp_mux_s;

    // Power mode of the surrounding chip
    typedef enum logic [1:0] {
        FPP_PWR_ACTIVE = 2'b00,
        FPP_PWR_SUBACTIVE = 2'b01,
        FPP_PWR_SLEEP = 2'b10,
        FPP_PWR_STANDBY = 2'b11
    } fpp_pwr_e;

    // Drive of the three two-way pins
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe_n;
    } fpp_drv_s;

endpackage

// >>> src/fpp_port.sv
// Four-pin port with serial and interrupt pin sharing, AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none

module fpp_port
    import fpp_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe_n,
    input wire logic serial_transmit_pin,
    input wire logic serial_clock_out,
    output logic serial_receive_pin,
    output logic serial_clock_in,
    output logic ext_irq_level
);

    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------

    // Word-aligned match of a bus address against a register offset
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
        logic [7:0] byte_addr;
        byte_addr = 8'(addr);
        reg_hit = (byte_addr[7:2] == off[7:2]);
    endfunction
    // Any mapped register
    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        reg_mapped = reg_hit(addr, FPP_OFF_DATA) || reg_hit(addr, FPP_OFF_DIR)
            || reg_hit(addr, FPP_OFF_MUX) || reg_hit(addr, FPP_OFF_PWR);
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [2:0] data_ff;
    logic [2:0] dir_ff;
    fpp_mux_s mux_ff;
    fpp_pwr_e pwr_ff;
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    fpp_drv_s drv_ff;
    logic rxd_ff;
    logic sck_in_ff;
    logic irq_ff;
    // ---------------------------------------------------------------
    // Write channel
    // ---------------------------------------------------------------
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic wr_lane0;
    logic nxt_aw_hold;
    logic nxt_w_hold;
    logic nxt_bvalid;
    // Address and data are taken independently, then joined
    assign aw_take = s_axi_awvalid && awready_ff;
    assign w_take = s_axi_wvalid && wready_ff;
    assign wr_fire = aw_hold_ff && w_hold_ff;
    assign wr_lane0 = wr_fire && wstrb_ff[0];
    assign nxt_aw_hold = wr_fire ? 1'b0 : (aw_hold_ff || aw_take);
    assign nxt_w_hold = wr_fire ? 1'b0 : (w_hold_ff || w_take);
    assign nxt_bvalid = wr_fire || (bvalid_ff && !s_axi_bready);

    // Register the write request and its response
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= FPP_RESP_OKAY;
        end
        else
        begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            if (aw_take)
                awaddr_ff <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            awready_ff <= !nxt_aw_hold && !nxt_bvalid;
            wready_ff <= !nxt_w_hold && !nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            if (wr_fire)
                bresp_ff <= reg_mapped(awaddr_ff) ? FPP_RESP_OKAY : FPP_RESP_SLVERR;
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic wr_data;
    logic wr_dir;
    logic wr_mux;
    logic wr_pwr;
    // Register selects on a completed write
    assign wr_data = wr_lane0 && reg_hit(awaddr_ff, FPP_OFF_DATA);
    assign wr_dir = wr_lane0 && reg_hit(awaddr_ff, FPP_OFF_DIR);
    assign wr_mux = wr_lane0 && reg_hit(awaddr_ff, FPP_OFF_MUX);
    assign wr_pwr = wr_lane0 && reg_hit(awaddr_ff, FPP_OFF_PWR);

    // Output latches, directions, mux control and power mode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_ff <= FPP_DATA_RST[2:0];
            dir_ff <= FPP_DIR_RST[2:0];
            mux_ff <= fpp_mux_s'(FPP_MUX_RST);
            pwr_ff <= FPP_PWR_ACTIVE;
        end
        else
        begin
            if (wr_data)
                data_ff <= wdata_ff[FPP_GPIO_LSB +: FPP_GPIO_W];
            if (wr_dir)
                dir_ff <= wdata_ff[FPP_GPIO_LSB +: FPP_GPIO_W];
            if (wr_mux)
                mux_ff <= fpp_mux_s'(wdata_ff[FPP_MUX_W-1:0]);
            if (wr_pwr)
                pwr_ff <= fpp_pwr_e'(wdata_ff[FPP_PWR_W-1:0]);
        end
    end

    // ---------------------------------------------------------------
    // Read channel
    // ---------------------------------------------------------------
    logic ar_take;
    logic [2:0] gpio_rd;
    logic [7:0] data_rd;
    logic [31:0] rd_word;
    logic nxt_rvalid;
    // Latch where driving, pin level where not
    assign gpio_rd = (dir_ff & data_ff) | (~dir_ff & pin_in[2:0]);
    assign data_rd = {FPP_DATA_UNUSED, pin_in[FPP_IN_PIN], gpio_rd};
    assign ar_take = s_axi_arvalid && arready_ff;
    assign nxt_rvalid = ar_take || (rvalid_ff && !s_axi_rready);

    // Read-data selection
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (reg_hit(s_axi_araddr, FPP_OFF_DATA))
            rd_word = {24'h00_0000, data_rd};
        else if (reg_hit(s_axi_araddr, FPP_OFF_DIR))
            rd_word = {24'h00_0000, FPP_DIR_READ};
        else if (reg_hit(s_axi_araddr, FPP_OFF_MUX))
            rd_word = {25'h000_0000, mux_ff};
        else if (reg_hit(s_axi_araddr, FPP_OFF_PWR))
            rd_word = {30'h0000_0000, pwr_ff};
    end
    // Capture the answer at the address handshake
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= FPP_RESP_OKAY;
        end
        else
        begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_take)
            begin
                rdata_ff <= rd_word;
                rresp_ff <= reg_mapped(s_axi_araddr) ? FPP_RESP_OKAY : FPP_RESP_SLVERR;
            end
        end
    end

    // ---------------------------------------------------------------
    // Pin multiplexer
    // ---------------------------------------------------------------
    logic tx_own;
    logic rx_own;
    logic sck_in_own;
    logic sck_out_own;
    logic pwr_run;
    logic pwr_hold;
    fpp_drv_s nxt_drv;
    // Alternate-function ownership of each pin
    assign tx_own = mux_ff.tx_en && mux_ff.tx_pin_ctl;
    assign rx_own = mux_ff.rx_en;
    assign sck_in_own = mux_ff.clk_en_hi;
    assign sck_out_own = !mux_ff.clk_en_hi && (mux_ff.clk_en_lo || mux_ff.comm_mode);
    assign pwr_run = (pwr_ff == FPP_PWR_ACTIVE) || (pwr_ff == FPP_PWR_SUBACTIVE);
    assign pwr_hold = (pwr_ff == FPP_PWR_SLEEP);

    // Next drive: general pins follow direction and latch
    always_comb
    begin
        nxt_drv.out = data_ff;
        nxt_drv.oe_n = ~dir_ff;
        if (tx_own)
        begin
            nxt_drv.out[2] = serial_transmit_pin;
            nxt_drv.oe_n[2] = 1'b0;
        end
        if (rx_own)
        begin
            nxt_drv.out[1] = 1'b0;
            nxt_drv.oe_n[1] = 1'b1;
        end
        if (sck_in_own)
        begin
            nxt_drv.out[0] = 1'b0;
            nxt_drv.oe_n[0] = 1'b1;
        end
        else if (sck_out_own)
        begin
            nxt_drv.out[0] = serial_clock_out;
            nxt_drv.oe_n[0] = 1'b0;
        end
        if (!pwr_run && !pwr_hold)
        begin
            nxt_drv.out = 3'h0;
            nxt_drv.oe_n = 3'h7;
        end
    end
    // Pin drive and alternate inputs, frozen in sleep
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv_ff <= '{out: 3'h0, oe_n: 3'h7};
            rxd_ff <= 1'b1;
            sck_in_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else if (!pwr_hold)
        begin
            drv_ff <= nxt_drv;
            rxd_ff <= rx_own ? pin_in[1] : 1'b1;
            sck_in_ff <= sck_in_own ? pin_in[0] : 1'b0;
            irq_ff <= mux_ff.irq_sel && pin_in[FPP_IN_PIN];
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign pin_out = drv_ff.out;
    assign pin_oe_n = drv_ff.oe_n;
    assign serial_receive_pin = rxd_ff;
    assign serial_clock_in = sck_in_ff;
    assign ext_irq_level = irq_ff;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    logic gpio2_run;
    // Pin 2 plainly general and the chip running
    assign gpio2_run = !tx_own && pwr_run;
    sequence rd_data_seq;
        ar_take && reg_hit(s_axi_araddr, FPP_OFF_DATA);
    endsequence
    sequence dir_write_seq;
        wr_dir && wdata_ff[2];
    endsequence
    data_upper_ones_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_data_seq |=> s_axi_rdata[7:4] == 4'hf && s_axi_rdata[3] == $past(pin_in[3]))
        else $error("data upper bits or input pin wrong");
    read_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_data_seq ##0 dir_ff[1] |=> s_axi_rdata[1] == $past(data_ff[1]))
        else $error("driven pin read does not return latch");
    read_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_data_seq ##0 !dir_ff[0] |=> s_axi_rdata[0] == $past(pin_in[0]))
        else $error("input pin read does not return pin level");
    reset_values_a: assert property (@(posedge clk)
        $rose(rst_n) |-> data_ff == 3'h0 && dir_ff == 3'h0 && pin_oe_n == 3'h7)
        else $error("reset values wrong");
    drive_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
        dir_write_seq ##1 (gpio2_run && dir_ff[2]) [*2] |-> pin_oe_n[2] == 1'b0
        && pin_out[2] == $past(data_ff[2]))
        else $error("direction one does not drive latch");
    alt_owns_a: assert property (@(posedge clk) disable iff (!rst_n)
        rx_own && pwr_run |=> pin_oe_n[1] == 1'b1)
        else $error("receive pin driven while owned by serial");
    dir_reads_ones_a: assert property (@(posedge clk) disable iff (!rst_n)
        ar_take && reg_hit(s_axi_araddr, FPP_OFF_DIR) |=> s_axi_rdata == 32'h0000_00ff)
        else $error("direction read not all ones");
    irq_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pwr_hold && !mux_ff.irq_sel |=> !ext_irq_level)
        else $error("interrupt request raised while pin is plain input");
    tx_output_a: assert property (@(posedge clk) disable iff (!rst_n)
        tx_own && pwr_run |=> !pin_oe_n[2] && pin_out[2] == $past(serial_transmit_pin))
        else $error("transmit pin not driven by serial data");
    sck_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        pwr_run && sck_out_own |=> !pin_oe_n[0] && pin_out[0] == $past(serial_clock_out))
        else $error("clock pin not driven as clock output");
    standby_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
        pwr_ff == FPP_PWR_STANDBY |=> pin_oe_n == 3'h7)
        else $error("pins driven in standby");
    sleep_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        pwr_hold |=> $stable(pin_oe_n) && $stable(pin_out))
        else $error("pins changed in sleep");
endmodule

`default_nettype wire

// >>> verification/fpp_board.sv
// Board-side model of the four port pins: wire resolution and float behaviour.
`timescale 1ns/1ps
`default_nettype none

module fpp_board
    import fpp_pkg::*;
(
    input wire logic clk,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    input wire logic [3:0] ext_val,
    input wire logic [3:0] ext_en,
    output logic [3:0] pin_in
);
    logic [3:0] last_ff;
    logic [3:0] dev_en;
    logic [3:0] dev_val;

    // ---------------------------------------------------------------
    // Wire resolution
    // ---------------------------------------------------------------
    // Device drives only where its enable is low; pin 3 is input only
    assign dev_en = {1'b0, ~pin_oe_n};
    assign dev_val = {1'b0, pin_out};
    // Pins driven by neither side flip every cycle, so a stale level is never trusted
    assign pin_in = (dev_en & dev_val) | (~dev_en & ext_en & ext_val)
        | (~dev_en & ~ext_en & ~last_ff);

    // Last wire level for the float pattern
    always_ff @(posedge clk)
    begin
        last_ff <= pin_in;
    end
endmodule

`default_nettype wire

// >>> verification/four_pin_io_port_with_serial_mux_tb.sv
// Self-checking testbench for the four-pin port.
`timescale 1ns/1ps
`default_nettype none

module four_pin_io_port_with_serial_mux_tb;
    import fpp_pkg::*;

    typedef struct packed {
        logic [6:0] mux;
        logic [2:0] dir;
        logic [2:0] dat;
        logic [3:0] ext;
        logic tx;
        logic ck;
        logic [2:0] oe;
        logic [2:0] out;
        logic [7:0] rd;
        logic [2:0] side;
    } fpp_row_s;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    logic [3:0] pin_in;
    logic [3:0] ext_val = 4'h0;
    logic [3:0] ext_en = 4'hf;
    logic [2:0] pin_out, pin_oe_n;
    logic tx_in = 1'b0, ck_out = 1'b0;
    logic rx_pin, ck_in, irq_lvl;
    int num_errors = 0;
    int checks_done = 0;
    fpp_row_s r;

    // Mux, dir, data, board, tx, clock; then oe, driven out, data read, side
    fpp_row_s rows [11] = '{
        '{7'h00, 3'h0, 3'h5, 4'ha, 1'b0, 1'b0, 3'h7, 3'h0, 8'hfa, 3'h1},
        '{7'h00, 3'h7, 3'h5, 4'h2, 1'b0, 1'b0, 3'h0, 3'h5, 8'hf5, 3'h1},
        '{7'h00, 3'h3, 3'h6, 4'hd, 1'b0, 1'b0, 3'h4, 3'h2, 8'hfe, 3'h1},
        '{7'h42, 3'h0, 3'h0, 4'h0, 1'b1, 1'b0, 3'h3, 3'h4, 8'hf4, 3'h1},
        '{7'h02, 3'h4, 3'h0, 4'h0, 1'b1, 1'b0, 3'h3, 3'h0, 8'hf0, 3'h1},
        '{7'h04, 3'h2, 3'h2, 4'h0, 1'b0, 1'b0, 3'h7, 3'h0, 8'hf2, 3'h0},
        '{7'h08, 3'h1, 3'h0, 4'h1, 1'b0, 1'b0, 3'h7, 3'h0, 8'hf0, 3'h3},
        '{7'h10, 3'h0, 3'h0, 4'h0, 1'b0, 1'b1, 3'h6, 3'h1, 8'hf1, 3'h1},
        '{7'h20, 3'h1, 3'h1, 4'h0, 1'b0, 1'b0, 3'h6, 3'h0, 8'hf1, 3'h1},
        '{7'h01, 3'h0, 3'h0, 4'h8, 1'b0, 1'b0, 3'h7, 3'h0, 8'hf8, 3'h5},
        '{7'h18, 3'h0, 3'h0, 4'h1, 1'b0, 1'b0, 3'h7, 3'h0, 8'hf1, 3'h3}
    };

    // 100 MHz clock
    always #5 clk = ~clk;

    fpp_port fpp_port_inst (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .serial_transmit_pin(tx_in), .serial_clock_out(ck_out),
        .serial_receive_pin(rx_pin), .serial_clock_in(ck_in),
        .ext_irq_level(irq_lvl)
    );

    fpp_board fpp_board_inst (
        .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in)
    );

    // ---------------------------------------------------------------
    // Compare and closing tasks
    // ---------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t pins got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Bus master tasks
    // ---------------------------------------------------------------
    // Write: both channels offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got)
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                got = 1'b1;
                bready <= 1'b0;
                chk_word({30'h0, bresp}, {30'h0, er});
            end
        end
    endtask

    // Read: data and response taken at the edge where rvalid is seen
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        logic got;
        got = 1'b0;
        d = 32'h0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got)
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                got = 1'b1;
                d = rdata;
                rready <= 1'b0;
                chk_word({30'h0, rresp}, {30'h0, er});
            end
        end
    endtask

    // Reset for two edges, pins checked while it is held
    task automatic pulse_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk_pin({pin_oe_n, pin_out}, {3'h7, 3'h0});
        rst_n <= 1'b1;
    endtask

    // Settle pins after a change, then look past the edge updates
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        pulse_reset();
        axi_rd(FPP_OFF_DATA, rd, FPP_RESP_OKAY);
        chk_word(rd, 32'hf0);
        foreach (rows[i])
        begin
            r = rows[i];
            ext_val <= r.ext;
            tx_in <= r.tx;
            ck_out <= r.ck;
            axi_wr(FPP_OFF_MUX, {25'h0, r.mux}, FPP_RESP_OKAY);
            axi_wr(FPP_OFF_DIR, {29'h0, r.dir}, FPP_RESP_OKAY);
            axi_wr(FPP_OFF_DATA, {29'h0, r.dat}, FPP_RESP_OKAY);
            settle();
            chk_pin({pin_oe_n, pin_out & ~pin_oe_n}, {r.oe, r.out});
            chk_pin({3'h0, irq_lvl, ck_in, rx_pin}, {3'h0, r.side});
            axi_rd(FPP_OFF_DATA, rd, FPP_RESP_OKAY);
            chk_word(rd, {24'h0, r.rd});
            axi_rd(FPP_OFF_MUX, rd, FPP_RESP_OKAY);
            chk_word(rd, {25'h0, r.mux});
            $display("row %0d done", i);
        end
        // Power modes: sleep holds, standby floats, subactive works
        axi_wr(FPP_OFF_MUX, 32'h0, FPP_RESP_OKAY);
        axi_wr(FPP_OFF_DIR, 32'h7, FPP_RESP_OKAY);
        axi_wr(FPP_OFF_DATA, 32'h5, FPP_RESP_OKAY);
        axi_wr(FPP_OFF_PWR, {30'h0, FPP_PWR_SLEEP}, FPP_RESP_OKAY);
        axi_wr(FPP_OFF_DATA, 32'h2, FPP_RESP_OKAY);
        settle();
        chk_pin({pin_oe_n, pin_out}, {3'h0, 3'h5});
        axi_wr(FPP_OFF_PWR, {30'h0, FPP_PWR_STANDBY}, FPP_RESP_OKAY);
        settle();
        chk_pin({pin_oe_n, pin_out}, {3'h7, 3'h0});
        axi_wr(FPP_OFF_PWR, {30'h0, FPP_PWR_SUBACTIVE}, FPP_RESP_OKAY);
        settle();
        chk_pin({pin_oe_n, pin_out}, {3'h0, 3'h2});
        $display("power test done");
        // Unmapped place and the write-only direction register
        axi_wr(8'h10, 32'hff, FPP_RESP_SLVERR);
        axi_rd(8'h10, rd, FPP_RESP_SLVERR);
        chk_word(rd, 32'h0);
        axi_rd(FPP_OFF_DIR, rd, FPP_RESP_OKAY);
        chk_word(rd, 32'hff);
        $display("bus test done");
        // Reset in mid-run with the pins driven
        ext_val <= 4'h5;
        pulse_reset();
        axi_rd(FPP_OFF_DATA, rd, FPP_RESP_OKAY);
        chk_word(rd, 32'hf5);
        axi_rd(FPP_OFF_MUX, rd, FPP_RESP_OKAY);
        chk_word(rd, 32'h0);
        axi_wr(FPP_OFF_DIR, 32'h7, FPP_RESP_OKAY);
        settle();
        chk_pin({pin_oe_n, pin_out}, {3'h0, 3'h0});
        axi_rd(FPP_OFF_DATA, rd, FPP_RESP_OKAY);
        chk_word(rd, 32'hf0);
        $display("reset test done");
        test_done();
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        #50000;
        num_errors++;
        test_done();
    end
endmodule

`default_nettype wire
